// >>> pct_port_ctrl.sv
// four-port power controller: class sequencing and fault timers
//
// Contract
// - each port runs in one of four modes
// - cut or startup fault removes power always
// - classify after detect, or manual on command
// - write class code into port status
// - map classification current band to 0..4
// - class 4 reported, powered as class 0
// - auto mode powers regardless of class
// - no classify when shutdown, powered, disabled; waiting for power-on, a new detection classifies even when disabled
// - cut timer full while over: off, fault
// - cut timeout from timing bits 3:2
// - count up over, down at 1/16
// - refuse repower until count back zero
// - ignore power-on command before count zero
// - auto repowers only after new detection
// - startup timer starts every power-up
// - startup timeout replaces cut during startup
// - disconnect timer held during startup
// - limit throughout startup gives startup fault
// - no fault if load appears in time
// - startup timeout from timing bits 5:4
// - short circuit releases gate after 100us
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module pct_port_ctrl
  import pct_pkg::*;
#(
  parameter int PORTS = 4,
  parameter logic [15:0] CUT_BASE = 16'h0800,
  parameter logic [15:0] START_BASE = 16'h0800,
  parameter logic [15:0] DIS_BASE = 16'h1000,
  parameter int GATE_HOLD = GATE_HOLD_CYC
)
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog front end, asynchronous
  input wire logic [3:0] detect_good_i,
  input wire logic [11:0] class_band_i,
  input wire logic [3:0] over_cut_i,
  input wire logic [3:0] at_limit_i,
  input wire logic [3:0] short_i,
  input wire logic [3:0] under_min_i,
  output logic [3:0] gate_on_o,
  output logic [3:0] class_run_o
);

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  logic [31:0] sy1_q;
  logic [31:0] sy2_q;
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sy1_q <= '0;
      sy2_q <= '0;
    end
    else
    begin
      sy1_q <= {detect_good_i, under_min_i, short_i, at_limit_i, over_cut_i,
        class_band_i};
      sy2_q <= sy1_q;
    end
  end
  logic [3:0] det2_q;
  assign det2_q = sy2_q[31:28]; // synchronised detection level
  logic [3:0] det_prev_q;
  logic [3:0] det_rise;
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      det_prev_q <= '0;
    else
      det_prev_q <= det2_q;
  end
  assign det_rise = det2_q & ~det_prev_q; // one new detection cycle

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [7:0] mode_q;
  logic [7:0] enable_q;
  logic [5:0] timing_q;
  logic [11:0] fault_q;
  logic [11:0] fault_set;
  logic [3:0] cmd_class;
  logic [3:0] cmd_pon;
  logic [3:0] cmd_poff;
  logic [7:0] status_b [PORTS];
  logic wr_en;
  logic rd_en;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign cmd_class = (wr_en && paddr_i == REG_CMD) ?
    pwdata_i[CMD_CLASS_LSB +: 4] : 4'h0;
  assign cmd_pon = (wr_en && paddr_i == REG_CMD) ?
    pwdata_i[CMD_PON_LSB +: 4] : 4'h0;
  assign cmd_poff = (wr_en && paddr_i == REG_CMD) ?
    pwdata_i[CMD_POFF_LSB +: 4] : 4'h0;

  // configuration writes
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mode_q <= MODE_RESET;
      enable_q <= ENABLE_RESET;
      timing_q <= TIMING_RESET;
    end
    else if (wr_en)
    begin
      if (paddr_i == REG_MODE)
        mode_q <= pwdata_i[7:0];
      if (paddr_i == REG_ENABLE)
        enable_q <= pwdata_i[7:0];
      if (paddr_i == REG_TIMING)
        timing_q <= pwdata_i[5:0];
    end
  end

  // fault bits: a hardware set wins over a software clear
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      fault_q <= '0;
    else if (wr_en && paddr_i == REG_FAULT_CLR)
      fault_q <= (fault_q & ~pwdata_i[11:0]) | fault_set;
    else
      fault_q <= fault_q | fault_set;
  end

  // apb answer: zero wait states, unmapped reads as zero with error
  logic mapped;
  assign mapped = paddr_i == REG_MODE || paddr_i == REG_ENABLE ||
    paddr_i == REG_CMD || paddr_i == REG_TIMING ||
    paddr_i == REG_STATUS || paddr_i == REG_FAULT ||
    paddr_i == REG_FAULT_CLR;
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !mapped;
      prdata_o <= '0;
      if (psel_i && !penable_i && !pwrite_i)
        unique case (paddr_i)
          REG_MODE: prdata_o <= {24'h0, mode_q};
          REG_ENABLE: prdata_o <= {24'h0, enable_q};
          REG_TIMING: prdata_o <= {26'h0, timing_q};
          REG_STATUS: prdata_o <= {status_b[3], status_b[2], status_b[1],
            status_b[0]};
          REG_FAULT: prdata_o <= {20'h0, fault_q};
          default: prdata_o <= '0;
        endcase
    end
  end

  // -----------------------------------------------------------------
  // per-port sequencers
  // -----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < PORTS; p++)
    begin : g_port
      pct_timer_if cut_if ();
      pct_timer_if st_if ();
      pct_state_t st_q;
      pct_mode_t mode;
      logic [2:0] class_q;
      logic [CNT_W-1:0] dis_q;
      logic [12:0] hold_q;
      logic gate_q;
      logic over;
      logic in_start;
      logic cut_trip;
      logic start_trip;
      logic dis_trip;
      logic limit_all_q;
      logic rearm_q;
      logic class_ok;

      assign mode = pct_mode_t'(mode_q[2*p +: 2]);
      assign over = sy2_q[12 + p];
      assign in_start = (st_q == ST_START);
      // no classification from idle in shutdown, powered or disabled
      assign class_ok = mode != MODE_SHUTDOWN && !gate_q &&
        enable_q[EN_CLASS_LSB + p];

      // cut timer counts outside startup, startup timer inside it
      assign cut_if.over = over && !in_start && gate_q;
      assign cut_if.clear = 1'b0;
      assign cut_if.full = pct_full(timing_q[TM_CUT_LSB +: 2],
        CUT_BASE);
      assign st_if.over = over && in_start;
      assign st_if.clear = 1'b0;
      assign st_if.full = pct_full(timing_q[TM_START_LSB +: 2],
        START_BASE);

      pct_duty_timer u_cut
      (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .t(cut_if.tmr)
      );
      pct_duty_timer u_st
      (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .t(st_if.tmr)
      );

      assign cut_trip = gate_q && !in_start && over &&
        cut_if.expired;
      // startup period ends after startup full count of ticks
      assign start_trip = in_start && dis_q >= st_if.full &&
        (limit_all_q || st_if.expired);
      assign dis_trip = st_q == ST_ON && enable_q[EN_DISC_LSB + p] &&
        dis_q >= pct_full(timing_q[TM_DIS_LSB +: 2], DIS_BASE);
      assign fault_set[FLT_CUT_LSB + p] = cut_trip;
      assign fault_set[FLT_START_LSB + p] = start_trip;
      assign fault_set[FLT_DIS_LSB + p] = dis_trip;

      // port sequencing
      always_ff @(posedge clk_sys_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          st_q <= ST_IDLE;
          class_q <= 3'h0;
          rearm_q <= 1'b0;
        end
        else if (mode == MODE_SHUTDOWN || cut_trip || start_trip ||
          dis_trip || cmd_poff[p])
        begin
          st_q <= ST_IDLE;
          rearm_q <= cut_trip || start_trip;
          if (mode == MODE_SHUTDOWN)
            class_q <= 3'h0;
        end
        else
        begin
          if (cut_if.zero && det2_q[p] && st_q == ST_IDLE)
            rearm_q <= 1'b0; // needs fresh detection after zero
          unique case (st_q)
            ST_IDLE:
              if (class_ok && (cmd_class[p] || (mode != MODE_MANUAL &&
                det2_q[p])))
                st_q <= ST_CLASS;
              else if (cmd_pon[p] && cut_if.zero &&
                mode != MODE_AUTO)
                st_q <= ST_START;
            ST_CLASS:
              if (dis_q == CNT_W'(CLASS_CYC))
              begin
                class_q <= pct_class_code(sy2_q[3*p +: 3]);
                if (mode == MODE_AUTO && det2_q[p] && cut_if.zero &&
                  !rearm_q)
                  st_q <= ST_START;
                else if (mode == MODE_SEMI)
                  st_q <= ST_WAIT_PON;
                else
                  st_q <= ST_IDLE;
              end
            ST_WAIT_PON:
              if (cmd_pon[p] && cut_if.zero)
                st_q <= ST_START;
              else if (det_rise[p])
                st_q <= ST_CLASS;
            ST_START:
              if (dis_q >= st_if.full)
                st_q <= ST_ON;
            ST_ON:
              st_q <= ST_ON;
            default:
              st_q <= ST_IDLE;
          endcase
        end
      end

      // startup tick count, then disconnect count (held in startup)
      always_ff @(posedge clk_sys_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          dis_q <= '0;
          limit_all_q <= 1'b0;
        end
        else if (st_q == ST_CLASS)
        begin
          // wait for the band to settle, leave with the count at zero
          dis_q <= (dis_q == CNT_W'(CLASS_CYC)) ? '0 : dis_q + 1'b1;
          limit_all_q <= 1'b1;
        end
        else if (st_q == ST_IDLE || st_q == ST_WAIT_PON)
        begin
          dis_q <= '0;
          limit_all_q <= 1'b1;
        end
        else if (in_start)
        begin
          limit_all_q <= limit_all_q && (sy2_q[16 + p] ||
            dis_q < CNT_W'(LIMIT_SETTLE_CYC));
          dis_q <= (dis_q >= st_if.full) ? '0 : dis_q + 1'b1;
        end
        else
          dis_q <= sy2_q[24 + p] ? dis_q + 1'b1 : '0;
      end

      // short circuit gate pull-down and release
      always_ff @(posedge clk_sys_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          hold_q <= '0;
          gate_q <= 1'b0;
        end
        else
        begin
          if (sy2_q[20 + p] && (st_q == ST_START || st_q == ST_ON))
            hold_q <= 13'(GATE_HOLD);
          else if (hold_q != '0)
            hold_q <= hold_q - 1'b1;
          gate_q <= (st_q == ST_START || st_q == ST_ON) &&
            !sy2_q[20 + p] && hold_q == '0;
        end
      end

      assign status_b[p] = {gate_q, class_q, 4'h0};
      assign gate_on_o[p] = gate_q;

      // classification pulse out
      always_ff @(posedge clk_sys_i or negedge rstn_i)
      begin
        if (!rstn_i)
          class_run_o[p] <= 1'b0;
        else
          class_run_o[p] <= (st_q == ST_CLASS);
      end

      // cut fault only when over at full count
      property p_cut;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        fault_set[FLT_CUT_LSB + p] |-> over && cut_if.expired;
      endproperty
      a_cut: assert property (p_cut) else $error("cut fault no cause");
    end
  endgenerate

endmodule

// >>> pct_pkg.sv
// package of register map, field layout and timing constants for port control
package pct_pkg;

  // -----------------------------------------------------------------
  // register byte offsets (apb, one aligned word each)
  // -----------------------------------------------------------------
  localparam logic [7:0] REG_MODE = 8'h00; // two mode bits per port
  localparam logic [7:0] REG_ENABLE = 8'h04; // class/disc enables
  localparam logic [7:0] REG_CMD = 8'h08; // write-only command pulses
  localparam logic [7:0] REG_TIMING = 8'h0C; // timeout selects
  localparam logic [7:0] REG_STATUS = 8'h20; // per-port status bytes
  localparam logic [7:0] REG_FAULT = 8'h24; // per-port fault bits
  localparam logic [7:0] REG_FAULT_CLR = 8'h28; // write one to clear

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int TM_DIS_LSB = 0;
  localparam int TM_CUT_LSB = 2;
  localparam int TM_START_LSB = 4;
  localparam int EN_CLASS_LSB = 0; // bits 3:0
  localparam int EN_DISC_LSB = 4; // bits 7:4
  localparam int CMD_CLASS_LSB = 0; // bits 3:0
  localparam int CMD_PON_LSB = 4; // bits 7:4
  localparam int CMD_POFF_LSB = 8; // bits 11:8
  localparam int ST_CLASS_LSB = 4; // class code bits 6:4 of status byte
  localparam int ST_POWER_BIT = 7;
  localparam int FLT_CUT_LSB = 0; // bits 3:0
  localparam int FLT_START_LSB = 4; // bits 7:4
  localparam int FLT_DIS_LSB = 8; // bits 11:8

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'hFF;
  localparam logic [5:0] TIMING_RESET = 6'h00;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int GATE_HOLD_US = 100;
  localparam int GATE_HOLD_CYC = GATE_HOLD_US * CLK_MHZ;
  localparam int SLOW_DIV = 16; // down-count at 1/16th of up rate
  localparam int CNT_W = 16;
  // class band passes the probe, the model and two flops before use
  localparam int CLASS_CYC = 8;
  // limit sense lags the gate by this many startup ticks
  localparam int LIMIT_SETTLE_CYC = 6;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MODE_SHUTDOWN = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_SEMI = 2'h2,
    MODE_AUTO = 2'h3
  } pct_mode_t;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_CLASS = 3'h1,
    ST_WAIT_PON = 3'h3,
    ST_START = 3'h2,
    ST_ON = 3'h6
  } pct_state_t;

  // map a measured class current code band to a class code
  // bands are resolved by the analog front end into a 3-bit band code per port
  function automatic logic [2:0] pct_class_code(input logic [2:0] band);
    pct_class_code = (band > 3'h4) ? 3'h0 : band;
  endfunction

  // select one of four full-count values
  function automatic logic [CNT_W-1:0] pct_full(input logic [1:0] sel,
    input logic [CNT_W-1:0] base);
    pct_full = base << sel;
  endfunction

endpackage

// >>> pct_timer_if.sv
// interface between the port sequencer and its duty-cycle timer
`timescale 1ns/100ps
interface pct_timer_if;
  logic over; // current above cut threshold
  logic clear; // reset count to zero
  logic [15:0] full; // selected full count
  logic expired; // count reached full
  logic zero; // count is zero
  modport ctl (output over, output clear, output full, input expired,
    input zero);
  modport tmr (input over, input clear, input full, output expired,
    output zero);
endinterface

// >>> pct_duty_timer.sv
// up/down duty-cycle protection counter
`timescale 1ns/100ps
module pct_duty_timer
  import pct_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  pct_timer_if.tmr t
);

  logic [CNT_W-1:0] cnt_q;
  logic [3:0] div_q;

  // -----------------------------------------------------------------
  // counter
  // -----------------------------------------------------------------
  // up every tick when over, down once per sixteen ticks otherwise
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q <= '0;
      div_q <= '0;
    end
    else if (t.clear)
    begin
      cnt_q <= '0;
      div_q <= '0;
    end
    else if (t.over)
    begin
      div_q <= '0;
      if (cnt_q < t.full)
        cnt_q <= cnt_q + 1'b1;
    end
    else
    begin
      div_q <= div_q + 1'b1;
      if (div_q == 4'(SLOW_DIV - 1) && cnt_q != '0)
        cnt_q <= cnt_q - 1'b1; // saturates at zero
    end
  end

  assign t.expired = (cnt_q >= t.full);
  assign t.zero = (cnt_q == '0);

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_up;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    t.over && !t.clear && cnt_q < t.full |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_up: assert property (p_up) else $error("count did not rise");

  property p_top;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    t.over && !t.clear && cnt_q >= t.full |=> cnt_q == $past(cnt_q);
  endproperty
  a_top: assert property (p_top) else $error("count past full");

  property p_slow;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !t.over && !t.clear && div_q != 4'(SLOW_DIV - 1) |=>
      cnt_q == $past(cnt_q);
  endproperty
  a_slow: assert property (p_slow) else $error("fast decay");

  property p_down;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !t.over && !t.clear && div_q == 4'(SLOW_DIV - 1) && cnt_q != '0 |=>
      cnt_q == $past(cnt_q) - 1'b1;
  endproperty
  a_down: assert property (p_down) else $error("no decay step");

  property p_floor;
    @(posedge clk_sys_i) disable iff (!rstn_i)
    !t.over && !t.clear && t.zero |=> t.zero;
  endproperty
  a_floor: assert property (p_floor) else $error("underflow");

  // main scenarios: a timeout, and a count that decays back to zero
  c_expired: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    t.expired);
  c_back_zero: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !t.zero ##1 t.zero);
  c_step: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !t.over && div_q == 4'(SLOW_DIV - 1) && !t.zero);

endmodule

// >>> pct_pd_model.sv
// powered-device model for the four cable ports
`timescale 1ns/100ps
module pct_pd_model
(
  input wire logic clk_sys_i,
  input wire logic [3:0] present_i,
  input wire logic [3:0] slow_i,
  input wire logic [11:0] cls_i,
  input wire logic [7:0] load_i,
  input wire logic [3:0] gate_on_i,
  input wire logic [3:0] class_run_i,
  output logic [3:0] detect_good_o,
  output logic [11:0] class_band_o,
  output logic [3:0] over_cut_o,
  output logic [3:0] at_limit_o,
  output logic [3:0] short_o,
  output logic [3:0] under_min_o
);
  logic [3:0] run_q;
  logic [1:0] ld;

  initial class_band_o = 12'h000;

  // load per port: 0 normal, 1 overload, 2 stuck in limit, 3 short
  // a slow pd shows its band one cycle late; outside the probe the band
  // toggles so a stale value is never taken for a fresh one
  always @(posedge clk_sys_i)
  begin
    run_q <= class_run_i;
    for (int p = 0; p < 4; p++)
    begin
      ld = load_i[2*p+:2];
      detect_good_o[p] <= present_i[p] & ~gate_on_i[p];
      if (class_run_i[p] && (!slow_i[p] || run_q[p]))
        class_band_o[3*p+:3] <= cls_i[3*p+:3];
      else
        class_band_o[3*p+:3] <= ~class_band_o[3*p+:3];
      over_cut_o[p] <= gate_on_i[p] & (ld == 2'h1 || ld == 2'h2);
      at_limit_o[p] <= gate_on_i[p] & (ld == 2'h2);
      short_o[p] <= gate_on_i[p] & (ld == 2'h3);
      under_min_o[p] <= ~gate_on_i[p];
    end
  end
endmodule

// >>> pct_port_ctrl_test.sv
// self-checking bench for the four-port power controller
`timescale 1ns/100ps
module pct_port_ctrl_test;
  import pct_pkg::*;
  localparam int HOLD = 40;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] det, over, lim, shrt, umin, gate, crun, present, slow;
  logic [3:0] seen = 4'h0;
  logic [3:0] seen_on = 4'h0;
  logic [11:0] band, cls;
  logic [7:0] load;
  int n_mismatch = 0;
  int total_checks = 0;

  pct_port_ctrl #(.CUT_BASE(16'h0010), .START_BASE(16'h0010),
    .DIS_BASE(16'h0020), .GATE_HOLD(HOLD)) DUT (.clk_sys_i(clk_sys),
    .rstn_i(rstn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .detect_good_i(det),
    .class_band_i(band), .over_cut_i(over), .at_limit_i(lim),
    .short_i(shrt), .under_min_i(umin), .gate_on_o(gate),
    .class_run_o(crun));

  pct_pd_model pd (.clk_sys_i(clk_sys), .present_i(present),
    .slow_i(slow), .cls_i(cls), .load_i(load), .gate_on_i(gate),
    .class_run_i(crun), .detect_good_o(det), .class_band_o(band),
    .over_cut_o(over), .at_limit_o(lim), .short_o(shrt),
    .under_min_o(umin));

  // sticky record of classification runs, and of runs on a powered port
  always @(posedge clk_sys)
  begin
    seen <= seen | crun;
    seen_on <= seen_on | (crun & gate);
  end

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic end_of_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input logic [31:0] msk);
    total_checks++;
    if ((got & msk) !== (exp & msk))
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time,
        got & msk, exp & msk);
    end
  endtask

  // pready and read data are taken at the rising edge that ends access
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 64)
    begin
      @(posedge clk_sys);
      n++;
    end
    rd = prdata;
    if (n >= 64)
      chk(32'h1, 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
    input logic [31:0] msk);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, msk);
  endtask

  // wait up to hi cycles for gate level lv, not sooner than lo;
  // with lo equal to hi the gate must keep the other level throughout
  task automatic wg(input int p, input logic lv, input int lo, input int hi);
    int n;
    logic ok;
    n = 0;
    while (gate[p] !== lv && n < hi)
    begin
      @(negedge clk_sys);
      n++;
    end
    ok = (gate[p] === lv) ? (n >= lo) : (lo == hi);
    chk({31'h0, ok}, 32'h1, 32'h1);
  endtask

  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    present = 4'h0;
    slow = 4'h2;
    cls = {3'h1, 3'h2, 3'h4, 3'h3};
    load = 8'h00;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    rchk(REG_MODE, {24'h0, MODE_RESET}, 32'hFF);
    rchk(REG_ENABLE, {24'h0, ENABLE_RESET}, 32'hFF);
    rchk(REG_TIMING, {26'h0, TIMING_RESET}, 32'h3F);
    apb(1'b1, 8'h3C, 32'hFFFFFFFF);
    rchk(REG_MODE, 32'h0, 32'hFF);
    // ports 0,1 auto, port 2 manual, port 3 shutdown
    present <= 4'hF;
    apb(1'b1, REG_MODE, 32'h1F);
    wg(0, 1'b1, 0, 3000);
    wg(1, 1'b1, 0, 3000);
    chk({28'h0, seen}, 32'h3, 32'hF);
    rchk(REG_STATUS, 32'h0000C0B0, 32'hF0F0F0F0);
    // manual port classifies only on command, then powers on command
    apb(1'b1, REG_CMD, 32'h4);
    repeat (300) @(negedge clk_sys);
    chk({28'h0, seen}, 32'h7, 32'hF);
    rchk(REG_STATUS, 32'h00200000, 32'h00F00000);
    apb(1'b1, REG_CMD, 32'h40);
    wg(2, 1'b1, 0, 200);
    repeat (200) @(negedge clk_sys);
    rchk(REG_FAULT, 32'h0, 32'h555);
    wg(0, 1'b1, 0, 0);
    // overcurrent cut on the manual port, early power-on ignored
    load <= 8'h10;
    wg(2, 1'b0, 8, 100);
    load <= 8'h00;
    rchk(REG_FAULT, 32'h004, 32'h044);
    apb(1'b1, REG_CMD, 32'h40);
    wg(2, 1'b1, 60, 60);
    repeat (400) @(negedge clk_sys);
    apb(1'b1, REG_CMD, 32'h40);
    wg(2, 1'b1, 0, 100);
    // cut select 2, startup select 1
    apb(1'b1, REG_TIMING, 32'h18);
    rchk(REG_TIMING, 32'h18, 32'h3F);
    apb(1'b1, REG_FAULT_CLR, 32'hFFF);
    rchk(REG_FAULT, 32'h0, 32'hFFF);
    // auto port: longer cut, slow decay, then redetect and repower
    load <= 8'h01;
    wg(0, 1'b0, 40, 200);
    rchk(REG_FAULT, 32'h001, 32'h011);
    load <= 8'h00;
    wg(0, 1'b1, 600, 5000);
    // port 1 stuck in limit through the whole startup
    apb(1'b1, REG_MODE, 32'h13);
    load <= 8'h08;
    apb(1'b1, REG_MODE, 32'h1F);
    wg(1, 1'b1, 0, 3000);
    wg(1, 1'b0, 20, 120);
    rchk(REG_FAULT, 32'h020, 32'h022);
    apb(1'b1, REG_MODE, 32'h13);
    load <= 8'h00;
    // short circuit: gate drops at once, released after the hold
    load <= 8'h03;
    wg(0, 1'b0, 0, 8);
    load <= 8'h00;
    wg(0, 1'b1, HOLD - 5, HOLD + 40);
    chk({28'h0, seen_on}, 32'h0, 32'hF);
    chk({28'h0, seen}, 32'h7, 32'h8);
    end_of_test();
  end

  // watchdog, well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end
endmodule
